/* design/adc_digital_control.sv */
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "adc_params.svh"
// What this block does
// R1: Resolution bit keeps top eight bits only
// R2: Control bit 0 enables the converter
// R3: Control bit 7 keeps running in standby
// R4: Accumulate code 0..6 means 1..64 samples
// R5: Sum accumulated samples into 16-bit result
// R6: Reference code 0 internal, 1 supply
// R7: Converter clock is core clock over 2^(n+1)
// R8: Bit 6 drives sample capacitance select out
// R9: Initial delay after enable or internal reference
// R10: Initial delay also after deep sleep wake
// R11: Delay variation increments inter-sample delay field
// R12: Inter-sample delay wraps from 0xF to 0
// R13: Inter-sample gap counts converter clock cycles
// R14: Sampling capacitor stays open during gap
// R15: Window mode below, above, inside, outside
// R16: Start bit begins conversion, reads busy
// R17: Flags clear on write one or result read
// R18: One shared staging byte for 16-bit access
// R19: Disabled converter ignores all start requests
// R20: Reserved bits read zero, ignore writes
module adc_digital_control
	import adc_pkg::*;
#(
	parameter int ADDR_W = 7
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              standby_sleep,
	input  wire logic              deep_wake,
	input  wire logic              debug_halt,
	input  wire logic              event_in,
	input  wire logic              core_done,
	input  wire logic [9:0]        core_data,
	output logic                   adc_clk,
	output logic                   sampling,
	output logic                   convert_start,
	output logic                   sample_cap_select,
	output logic      [1:0]        reference_select,
	output logic      [4:0]        input_select,
	output logic                   duty_cycle_trim,
	output logic                   irq_rdy_req,
	output logic                   irq_win_req
);

	logic [7:0]  enable_ctrl_r;
	logic [7:0]  accum_ctrl_r;
	logic [7:0]  refclk_ctrl_r;
	logic [7:0]  delay_ctrl_r;
	logic [7:0]  winmode_ctrl_r;
	logic [7:0]  samplen_ctrl_r;
	logic [7:0]  input_sel_r;
	logic [7:0]  event_ctrl_r;
	logic [7:0]  irq_enable_r;
	logic [7:0]  debug_ctrl_r;
	logic [7:0]  duty_calibration_r;
	logic [7:0]  staging_r;
	logic [1:0]  flags_r;
	logic [1:0]  irq_r;
	logic [15:0] result_r;
	logic [15:0] win_low_r;
	logic [15:0] win_high_r;
	logic [15:0] acc_r;
	logic [7:0]  clock_divider_cnt_r;
	logic [8:0]  tick_cnt_r;
	logic [6:0]  samples_left_r;
	logic        init_pending_r;
	logic        enable_prev_r;
	logic        event_prev_r;
	logic        adc_clk_r;
	logic        sampling_r;
	logic        convert_start_r;
	logic        ack_r;
	logic [31:0] rdata_r;
	conv_state_t state_r;

	logic        access;
	logic        wr;
	logic        rd;
	logic [4:0]  idx;
	logic [7:0]  wbyte;
	logic        converter_on;
	logic        run_ok;
	logic        tick;
	logic [7:0]  clock_divider_mask;
	logic [8:0]  init_ticks;
	logic [6:0]  sample_total;
	logic [15:0] sample_val;
	logic [15:0] acc_sum;
	logic        win_hit;
	logic        start_req;
	logic        sample_done;
	logic        conv_last;
	logic        result_read;
	logic [1:0]  flag_set;
	logic [1:0]  flag_clr;
	logic [1:0]  flags_nxt;
	logic [1:0]  irq_en_nxt;
	logic [7:0]  rbyte;

	// Accesses act only in the cycle before ack, so each is taken once
	assign access = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr     = access & wb_we_i & wb_sel_i[0];
	assign rd     = access & ~wb_we_i;
	assign idx    = wb_adr_i[6:2];
	assign wbyte  = wb_dat_i[7:0];

	assign converter_on = enable_ctrl_r[`BIT_ENABLE]; // R2
	// Sleep and debug halts freeze the sequence rather than abort it
	assign run_ok = converter_on
		& (~standby_sleep | enable_ctrl_r[`BIT_STANDBY_RUN]) // R3
		& (~debug_halt | debug_ctrl_r[0]);

	assign clock_divider_mask = 8'((9'h002 << refclk_ctrl_r[2:0]) - 9'h001); // R7
	assign tick = run_ok & ((clock_divider_cnt_r & clock_divider_mask) == clock_divider_mask);

	// R9: reserved delay codes are taken as no delay
	assign init_ticks = (delay_ctrl_r[7:5] == 3'h0
		|| delay_ctrl_r[7:5] > `INIT_MAX_CODE) ? 9'h000
		: 9'(`INIT_UNIT_TICKS << delay_ctrl_r[7:5]);

	// R4: the reserved code falls back to a single sample
	assign sample_total = (accum_ctrl_r[2:0] > `ACCUM_MAX_CODE) ? 7'h01
		: 7'(7'h01 << accum_ctrl_r[2:0]);

	assign sample_val = enable_ctrl_r[`BIT_RES_SEL] ? // R1
		{8'h00, core_data[9:2]} : {6'h00, core_data};
	assign acc_sum = acc_r + sample_val; // R5

	// R15
	always_comb begin
		case (winmode_ctrl_r[2:0])
		`WIN_BELOW:   win_hit = acc_sum < win_low_r;
		`WIN_ABOVE:   win_hit = acc_sum > win_high_r;
		`WIN_INSIDE:  win_hit = (acc_sum > win_low_r)
			&& (acc_sum < win_high_r);
		`WIN_OUTSIDE: win_hit = (acc_sum < win_low_r)
			|| (acc_sum > win_high_r);
		default:      win_hit = 1'b0;
		endcase
	end

	// R16, R19
	assign start_req = (wr && idx == `IDX_COMMAND && wbyte[0])
		|| (event_ctrl_r[0] && event_in && !event_prev_r);

	assign sample_done = (state_r == ST_CONVERT) && core_done && run_ok;
	assign conv_last   = sample_done && samples_left_r == 7'h01;
	assign result_read = rd && (idx == `IDX_RESULT_LO || idx == `IDX_RESULT_HI);
	assign flag_set    = {conv_last & win_hit, conv_last};
	// R17
	assign flag_clr = (wr && idx == `IDX_IRQ_FLAGS) ?
		wbyte[1:0] : {2{result_read}};
	assign flags_nxt  = (flags_r & ~flag_clr) | flag_set;
	assign irq_en_nxt = (wr && idx == `IDX_IRQ_ENABLE) ?
		wbyte[1:0] : irq_enable_r[1:0];

	always_ff @(posedge core_clk) begin
		if (reset || !converter_on) begin
			clock_divider_cnt_r <= `RESET_BYTE;
			adc_clk_r   <= 1'b0;
		end else begin
			clock_divider_cnt_r <= clock_divider_cnt_r + 8'h01;
			adc_clk_r   <= clock_divider_cnt_r[refclk_ctrl_r[2:0]];
		end
	end

	// Conversion sequence
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r         <= ST_IDLE;
			tick_cnt_r      <= 9'h000;
			samples_left_r  <= 7'h00;
			acc_r           <= `RESET_WORD;
			result_r        <= `RESET_WORD;
			sampling_r      <= 1'b0;
			convert_start_r <= 1'b0;
		end else begin
			convert_start_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				sampling_r <= 1'b0;
				if (start_req && converter_on) begin // R19
					samples_left_r <= sample_total;
					acc_r          <= `RESET_WORD;
					tick_cnt_r     <= 9'h000;
					state_r        <= init_pending_r ? ST_INIT : ST_SAMPLE;
					sampling_r     <= !init_pending_r;
				end
			end
			ST_INIT: begin
				if (tick) tick_cnt_r <= tick_cnt_r + 9'h001;
				if (tick_cnt_r >= init_ticks) begin // R9
					state_r    <= ST_SAMPLE;
					sampling_r <= 1'b1;
					tick_cnt_r <= 9'h000;
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					if (tick_cnt_r + 9'h001 >= 9'({1'b0,
						samplen_ctrl_r[4:0]} + `SAMPLE_BASE_TICKS)) begin
						state_r         <= ST_CONVERT;
						sampling_r      <= 1'b0;
						convert_start_r <= 1'b1;
						tick_cnt_r      <= 9'h000;
					end else begin
						tick_cnt_r <= tick_cnt_r + 9'h001;
					end
				end
			end
			ST_CONVERT: begin
				if (sample_done) begin
					acc_r          <= acc_sum; // R5
					samples_left_r <= samples_left_r - 7'h01;
					state_r        <= conv_last ? ST_IDLE : ST_GAP;
					if (conv_last) result_r <= acc_sum;
				end
			end
			ST_GAP: begin
				sampling_r <= 1'b0; // R14
				if (tick) tick_cnt_r <= tick_cnt_r + 9'h001;
				if (tick_cnt_r >= {5'h00, delay_ctrl_r[3:0]}) begin // R13
					state_r    <= ST_SAMPLE;
					sampling_r <= 1'b1;
					tick_cnt_r <= 9'h000;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
			if (!converter_on) begin
				state_r    <= ST_IDLE;
				sampling_r <= 1'b0;
			end
		end
	end

	// Pending start-up delay, consumed by the next start
	always_ff @(posedge core_clk) begin
		if (reset) begin
			init_pending_r <= 1'b1;
			enable_prev_r  <= 1'b0;
			event_prev_r   <= 1'b0;
		end else begin
			enable_prev_r <= converter_on;
			event_prev_r  <= event_in;
			if ((converter_on && !enable_prev_r) || deep_wake) begin // R9 R10
				init_pending_r <= 1'b1;
			end else if (wr && idx == `IDX_REFCLK_CTRL
				&& wbyte[5:4] == `REF_INTERNAL
				&& refclk_ctrl_r[5:4] != `REF_INTERNAL) begin // R9
				init_pending_r <= 1'b1;
			end else if (state_r == ST_IDLE && start_req && converter_on) begin
				init_pending_r <= 1'b0;
			end
		end
	end

	// Control registers; reserved bits masked off on write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			enable_ctrl_r  <= `RESET_BYTE;
			accum_ctrl_r   <= `RESET_BYTE;
			refclk_ctrl_r  <= `RESET_BYTE;
			winmode_ctrl_r <= `RESET_BYTE;
			samplen_ctrl_r <= `RESET_BYTE;
			input_sel_r    <= `RESET_BYTE;
			event_ctrl_r   <= `RESET_BYTE;
			irq_enable_r   <= `RESET_BYTE;
			debug_ctrl_r   <= `RESET_BYTE;
			duty_calibration_r        <= `RESET_BYTE;
		end else if (wr) begin
			case (idx)
			`IDX_ENABLE_CTRL: begin
				enable_ctrl_r <= wbyte & `MASK_ENABLE_CTRL; // R20
			end
			`IDX_ACCUM_CTRL:   accum_ctrl_r   <= wbyte & `MASK_ACCUM_CTRL;
			`IDX_REFCLK_CTRL:  refclk_ctrl_r  <= wbyte & `MASK_REFCLK_CTRL;
			`IDX_WINMODE_CTRL: winmode_ctrl_r <= wbyte & `MASK_WINMODE_CTRL;
			`IDX_SAMPLEN_CTRL: samplen_ctrl_r <= wbyte & `MASK_SAMPLEN_CTRL;
			`IDX_INPUT_SEL:    input_sel_r    <= wbyte & `MASK_INPUT_SEL;
			`IDX_EVENT_CTRL:   event_ctrl_r   <= wbyte & `MASK_BIT0;
			`IDX_IRQ_ENABLE:   irq_enable_r   <= wbyte & `MASK_FLAGS;
			`IDX_DEBUG_CTRL:   debug_ctrl_r   <= wbyte & `MASK_BIT0;
			`IDX_DUTY_CALIBRATION:        duty_calibration_r        <= wbyte & `MASK_BIT0;
			default: ;
			endcase
		end
	end

	// Software write to the delay register wins over the auto increment
	always_ff @(posedge core_clk) begin
		if (reset) begin
			delay_ctrl_r <= `RESET_BYTE;
		end else if (wr && idx == `IDX_DELAY_CTRL) begin
			delay_ctrl_r <= wbyte;
		end else if (sample_done && delay_ctrl_r[`BIT_DELAY_VAR]) begin
			delay_ctrl_r[3:0] <= delay_ctrl_r[3:0] + 4'h1; // R11 R12
		end
	end

	// Flags: a set in the same cycle as a clear wins; requests are
	// registered from the next values so they keep the flags' timing
	always_ff @(posedge core_clk) begin
		if (reset) begin
			flags_r <= 2'b00;
			irq_r   <= 2'b00;
		end else begin
			flags_r <= flags_nxt; // R17
			irq_r   <= flags_nxt & irq_en_nxt;
		end
	end

	// R18
	always_ff @(posedge core_clk) begin
		if (reset) begin
			staging_r  <= `RESET_BYTE;
			win_low_r  <= `RESET_WORD;
			win_high_r <= `RESET_WORD;
		end else if (wr) begin
			case (idx)
			`IDX_STAGING, `IDX_WINLO_LO, `IDX_WINHI_LO: staging_r <= wbyte;
			`IDX_WINLO_HI: win_low_r  <= {wbyte, staging_r};
			`IDX_WINHI_HI: win_high_r <= {wbyte, staging_r};
			default: ;
			endcase
		end else if (rd) begin
			case (idx)
			`IDX_RESULT_LO: staging_r <= result_r[15:8];
			`IDX_WINLO_LO:  staging_r <= win_low_r[15:8];
			`IDX_WINHI_LO:  staging_r <= win_high_r[15:8];
			default: ;
			endcase
		end
	end

	always_comb begin
		case (idx)
		`IDX_ENABLE_CTRL:  rbyte = enable_ctrl_r;
		`IDX_ACCUM_CTRL:   rbyte = accum_ctrl_r;
		`IDX_REFCLK_CTRL:  rbyte = refclk_ctrl_r;
		`IDX_DELAY_CTRL:   rbyte = delay_ctrl_r;
		`IDX_WINMODE_CTRL: rbyte = winmode_ctrl_r;
		`IDX_SAMPLEN_CTRL: rbyte = samplen_ctrl_r;
		`IDX_INPUT_SEL:    rbyte = input_sel_r;
		`IDX_COMMAND:      rbyte = {7'h00, state_r != ST_IDLE}; // R16
		`IDX_EVENT_CTRL:   rbyte = event_ctrl_r;
		`IDX_IRQ_ENABLE:   rbyte = irq_enable_r;
		`IDX_IRQ_FLAGS:    rbyte = {6'h00, flags_r};
		`IDX_DEBUG_CTRL:   rbyte = debug_ctrl_r;
		`IDX_STAGING:      rbyte = staging_r;
		`IDX_RESULT_LO:    rbyte = result_r[7:0];
		`IDX_WINLO_LO:     rbyte = win_low_r[7:0];
		`IDX_WINHI_LO:     rbyte = win_high_r[7:0];
		`IDX_RESULT_HI, `IDX_WINLO_HI, `IDX_WINHI_HI: rbyte = staging_r;
		`IDX_DUTY_CALIBRATION:        rbyte = duty_calibration_r;
		default:           rbyte = `RESET_BYTE; // R20
		endcase
	end

	// Single wait state: ack one edge after the request is seen
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r   <= access;
			rdata_r <= rd ? {24'h00_0000, rbyte} : 32'h0000_0000;
		end
	end

	assign wb_ack_o          = ack_r;
	assign wb_dat_o          = rdata_r;
	assign adc_clk           = adc_clk_r;
	assign sampling          = sampling_r;
	assign convert_start     = convert_start_r;
	assign sample_cap_select = refclk_ctrl_r[`BIT_SAMPLE_CAP]; // R8
	assign reference_select  = refclk_ctrl_r[5:4]; // R6
	assign input_select      = input_sel_r[4:0];
	assign duty_cycle_trim   = duty_calibration_r[0];
	assign irq_rdy_req       = irq_r[`BIT_RDY];
	assign irq_win_req       = irq_r[`BIT_WIN];

endmodule

/* design/adc_params.svh */
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_ENABLE_CTRL   5'h00
`define IDX_ACCUM_CTRL    5'h01
`define IDX_REFCLK_CTRL   5'h02
`define IDX_DELAY_CTRL    5'h03
`define IDX_WINMODE_CTRL  5'h04
`define IDX_SAMPLEN_CTRL  5'h05
`define IDX_INPUT_SEL     5'h06
`define IDX_COMMAND       5'h08
`define IDX_EVENT_CTRL    5'h09
`define IDX_IRQ_ENABLE    5'h0A
`define IDX_IRQ_FLAGS     5'h0B
`define IDX_DEBUG_CTRL    5'h0C
`define IDX_STAGING       5'h0D
`define IDX_RESULT_LO     5'h10
`define IDX_RESULT_HI     5'h11
`define IDX_WINLO_LO      5'h12
`define IDX_WINLO_HI      5'h13
`define IDX_WINHI_LO      5'h14
`define IDX_WINHI_HI      5'h15
`define IDX_DUTY_CALIBRATION         5'h16

// Writable masks, reserved bits read zero
`define MASK_ENABLE_CTRL  8'h85
`define MASK_ACCUM_CTRL   8'h07
`define MASK_REFCLK_CTRL  8'h77
`define MASK_WINMODE_CTRL 8'h07
`define MASK_SAMPLEN_CTRL 8'h1F
`define MASK_INPUT_SEL    8'h1F
`define MASK_BIT0         8'h01
`define MASK_FLAGS        8'h03
`define RESET_BYTE        8'h00
`define RESET_WORD        16'h0000

// Field positions
`define BIT_ENABLE        0
`define BIT_RES_SEL       2
`define BIT_STANDBY_RUN   7
`define BIT_SAMPLE_CAP    6
`define BIT_DELAY_VAR     4
`define BIT_RDY           0
`define BIT_WIN           1

// Field codes
`define REF_INTERNAL      2'h0
`define ACCUM_MAX_CODE    3'h6
`define INIT_MAX_CODE     3'h5
`define WIN_BELOW         3'h1
`define WIN_ABOVE         3'h2
`define WIN_INSIDE        3'h3
`define WIN_OUTSIDE       3'h4
`define SAMPLE_BASE_TICKS 6'h02
`define INIT_UNIT_TICKS   9'h008

`endif

/* design/adc_pkg.sv */
package adc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_INIT    = 3'b001,
		ST_SAMPLE  = 3'b010,
		ST_CONVERT = 3'b011,
		ST_GAP     = 3'b100
	} conv_state_t;
endpackage

/* test/adc_checker_props.sv */
`timescale 1ns/1ps
module adc_checker #(
	parameter int ADDR_W = 7
) (
	input wire logic              core_clk,
	input wire logic              reset,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire logic              core_done,
	input wire logic              sampling,
	input wire logic              convert_start,
	input wire logic              sample_cap_select,
	input wire logic [1:0]        reference_select,
	input wire logic              irq_rdy_req,
	input wire logic              irq_win_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// A sample landing in the same edge may set the flag again
	sequence s_res_read;
		wb_ack_o && !wb_we_i && wb_adr_i[6:3] == 4'h8 && !$past(core_done);
	endsequence
	a_ack_next: assert property (s_take |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside answer");
	a_cfg_write: assert property (
		$changed({sample_cap_select, reference_select}) |-> wb_ack_o && wb_we_i)
		else $error("config output moved without write");
	a_conv_after: assert property (convert_start |-> $past(sampling))
		else $error("convert without sampling");
	a_conv_pulse: assert property (convert_start |=> !convert_start)
		else $error("convert start too long");
	a_read_clears: assert property (
		s_res_read |-> !irq_rdy_req && !irq_win_req)
		else $error("flag kept after result read");
	a_irq_cause: assert property (
		$rose(irq_rdy_req) || $rose(irq_win_req)
		|-> $past(core_done) || (wb_ack_o && wb_we_i))
		else $error("request raised without cause");
endmodule
bind adc_digital_control adc_checker #(.ADDR_W(ADDR_W)) i_adc_checker (
	.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_done(core_done),
	.sampling(sampling), .convert_start(convert_start),
	.sample_cap_select(sample_cap_select),
	.reference_select(reference_select),
	.irq_rdy_req(irq_rdy_req), .irq_win_req(irq_win_req));

/* test/adc_digital_control_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module adc_digital_control_test;
	logic        core_clk = 1'h0;
	logic        reset = 1'h1;
	logic        cyc = 1'h0;
	logic        stb = 1'h0;
	logic        we = 1'h0;
	logic [6:0]  adr = 7'h00;
	logic [31:0] dat_i = 32'h0;
	logic        event_in = 1'h0;
	logic        standby_sleep = 1'h0;
	logic        deep_wake = 1'h0;
	logic [9:0]  value = 10'h000;
	logic [3:0]  latency = 4'h3;
	logic [31:0] dat_o;
	logic [9:0]  core_data;
	logic [1:0]  reference_select;
	logic [4:0]  input_select;
	logic        duty_cycle_trim;
	logic        ack, core_done, adc_clk, sampling, convert_start;
	logic        sample_cap_select, irq_rdy_req, irq_win_req;
	int          fails = 0, compares = 0, starts = 0, run = 0, last_run = 0;

	adc_digital_control i_adc_digital_control (
		.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_i),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .standby_sleep(standby_sleep),
		.deep_wake(deep_wake), .debug_halt(1'h0), .event_in(event_in),
		.core_done(core_done), .core_data(core_data), .adc_clk(adc_clk),
		.sampling(sampling), .convert_start(convert_start),
		.sample_cap_select(sample_cap_select),
		.reference_select(reference_select),
		.input_select(input_select),
		.duty_cycle_trim(duty_cycle_trim), .irq_rdy_req(irq_rdy_req),
		.irq_win_req(irq_win_req));
	analog_core_model i_analog_core_model (
		.core_clk(core_clk), .convert_start(convert_start),
		.latency(latency), .value(value), .core_done(core_done),
		.core_data(core_data));

	always #10 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		if (convert_start === 1'h1)
			starts++;
		if (sampling === 1'h1)
			run++;
		else if (run != 0) begin
			last_run = run;
			run = 0;
		end
	end

	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [4:0] i,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {i, 2'h0};
		dat_i <= {24'h0, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		`CHK("ack", 1'h1, ack)
		q = dat_o[7:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'h1, i, d, q);
	endtask

	task automatic rc(input logic [4:0] i, input logic [7:0] e, string nm);
		logic [7:0] q;
		bus(1'h0, i, 8'h00, q);
		`CHK(nm, e, q)
	endtask

	task automatic conv(input logic [15:0] e, output int n, output logic w);
		n = 0;
		wr(5'h08, 8'h01);
		rc(5'h08, 8'h01, "busy");
		while (irq_rdy_req !== 1'h1 && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		w = irq_win_req;
		`CHK("ready", 1'h1, irq_rdy_req)
		rc(5'h08, 8'h00, "done");
		rc(5'h10, e[7:0], "result low");
		rc(5'h11, e[15:8], "result high");
		`CHK("flags", 2'h0, {irq_win_req, irq_rdy_req})
	endtask

	task automatic t_regs();
		for (int i = 0; i < 24; i++)
			rc(i[4:0], 8'h00, "reset value");
		wr(5'h00, 8'hFE);
		rc(5'h00, 8'h84, "enable ctrl");
		wr(5'h01, 8'hFF);
		rc(5'h01, 8'h07, "accum ctrl");
		wr(5'h02, 8'hFF);
		rc(5'h02, 8'h77, "ref ctrl");
		`CHK("cap select", 1'h1, sample_cap_select)
		wr(5'h02, 8'h10);
		`CHK("ref supply", 2'h1, reference_select)
		wr(5'h07, 8'hFF);
		rc(5'h07, 8'h00, "unmapped");
		wr(5'h06, 8'hFF);
		rc(5'h06, 8'h1F, "input select");
		`CHK("input pin", 5'h1F, input_select)
		wr(5'h16, 8'hFF);
		rc(5'h16, 8'h01, "duty_calibration");
		`CHK("trim pin", 1'h1, duty_cycle_trim)
		wr(5'h00, 8'h00);
		wr(5'h01, 8'h00);
		wr(5'h02, 8'h00);
		`CHK("ref internal", 2'h0, reference_select)
		$display("regs done");
	endtask

	task automatic t_stage();
		wr(5'h12, 8'h34);
		rc(5'h0D, 8'h34, "staging");
		wr(5'h13, 8'h01);
		rc(5'h12, 8'h34, "low thr low");
		rc(5'h13, 8'h01, "low thr high");
		rc(5'h0D, 8'h01, "staging");
		$display("stage done");
	endtask

	task automatic t_off();
		int s;
		wr(5'h09, 8'h01);
		s = starts;
		wr(5'h08, 8'h01);
		event_in <= 1'h1;
		repeat (20) @(posedge core_clk);
		event_in <= 1'h0;
		rc(5'h08, 8'h00, "cmd off");
		`CHK("no start", s, starts)
		`CHK("clk idle", 1'h0, adc_clk)
		wr(5'h09, 8'h00);
		$display("off done");
	endtask

	task automatic t_single();
		int   n;
		int   s;
		logic w;
		value <= 10'h2A7;
		wr(5'h0A, 8'h03);
		wr(5'h03, 8'hA0);
		wr(5'h00, 8'h01);
		conv(16'h02A7, n, w);
		`CHK("init wait", 1'h1, n >= 500)
		conv(16'h02A7, n, w);
		`CHK("no init", 1'h1, n < 100)
		wr(5'h02, 8'h10);
		wr(5'h02, 8'h00);
		conv(16'h02A7, n, w);
		`CHK("ref init", 1'h1, n >= 500)
		wr(5'h03, 8'h00);
		wr(5'h00, 8'h05);
		conv(16'h00A9, n, w);
		wr(5'h09, 8'h01);
		s = starts;
		event_in <= 1'h1;
		repeat (100) @(posedge core_clk);
		event_in <= 1'h0;
		`CHK("event start", s + 1, starts)
		`CHK("event ready", 1'h1, irq_rdy_req)
		rc(5'h10, 8'hA9, "event result");
		wr(5'h09, 8'h00);
		wr(5'h00, 8'h01);
		$display("single done");
	endtask

	task automatic t_sleep();
		int   n;
		logic w;
		standby_sleep <= 1'h1;
		wr(5'h00, 8'h81);
		conv(16'h02A7, n, w);
		wr(5'h00, 8'h01);
		wr(5'h08, 8'h01);
		repeat (200) @(posedge core_clk);
		`CHK("standby hold", 1'h0, irq_rdy_req)
		standby_sleep <= 1'h0;
		repeat (100) @(posedge core_clk);
		`CHK("standby resume", 1'h1, irq_rdy_req)
		rc(5'h10, 8'hA7, "resume result");
		wr(5'h03, 8'hA0);
		deep_wake <= 1'h1;
		@(posedge core_clk);
		deep_wake <= 1'h0;
		conv(16'h02A7, n, w);
		`CHK("wake init", 1'h1, n >= 500)
		wr(5'h03, 8'h00);
		$display("sleep done");
	endtask

	task automatic t_div_accum();
		int   n;
		logic w;
		for (int c = 0; c < 8; c++) begin
			wr(5'h02, c[7:0]);
			conv(16'h02A7, n, w);
			`CHK("divider", 1'h1, last_run >= (2 << c))
			`CHK("divider", 1'h1, last_run <= (4 << c) + 2)
		end
		wr(5'h02, 8'h00);
		// Code 7 is reserved and taken as a single sample
		for (int c = 0; c < 8; c++) begin
			latency <= c[3:0] + 4'h1;
			wr(5'h01, c[7:0]);
			conv(16'h02A7 << (c == 7 ? 0 : c), n, w);
		end
		wr(5'h03, 8'h1F);
		wr(5'h01, 8'h01);
		conv(16'h054E, n, w);
		rc(5'h03, 8'h11, "delay wrap");
		wr(5'h03, 8'h00);
		wr(5'h01, 8'h00);
		$display("div accum done");
	endtask

	task automatic t_window();
		logic [15:0] v;
		logic        e;
		logic        w;
		int          n;
		wr(5'h12, 8'h00);
		wr(5'h13, 8'h01);
		wr(5'h14, 8'h00);
		wr(5'h15, 8'h02);
		for (int m = 0; m < 5; m++) begin
			wr(5'h04, m[7:0]);
			for (int k = 0; k < 3; k++) begin
				v = 16'h0050 + 16'(k) * 16'h0100;
				value <= v[9:0];
				case (m)
					1: e = v < 16'h0100;
					2: e = v > 16'h0200;
					3: e = v > 16'h0100 && v < 16'h0200;
					4: e = v < 16'h0100 || v > 16'h0200;
					default: e = 1'h0;
				endcase
				conv(v, n, w);
				`CHK("window", e, w)
			end
		end
		$display("window done");
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 1'h0;
		@(posedge core_clk);
		t_regs();
		t_stage();
		t_off();
		t_single();
		t_sleep();
		t_div_accum();
		t_window();
		end_of_test();
	end

	// Longest path is the accumulate sweep up to 64 samples, well under this span
	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		end_of_test();
	end
endmodule

/* test/analog_core_model.sv */
`timescale 1ns/1ps
module analog_core_model (
	input  wire logic       core_clk,
	input  wire logic       convert_start,
	input  wire logic [3:0] latency,
	input  wire logic [9:0] value,
	output logic            core_done,
	output logic [9:0]      core_data
);
	int cnt = 0;
	initial begin
		core_done = 1'h0;
		core_data = 10'h000;
	end
	// Latency from the bench, so prompt and slow cores both occur
	always @(posedge core_clk) begin
		core_done <= 1'h0;
		if (cnt == 1) begin
			core_done <= 1'h1;
			core_data <= value;
		end else
			core_data <= ~core_data; // Data is junk outside done
		if (convert_start === 1'h1)
			cnt <= int'(latency) + 1;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule
